/* File: rx_port_defs.svh */
`ifndef RX_PORT_DEFS_SVH
`define RX_PORT_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_SELFTEST    8'h08

// ****************************************************************
// control field positions and reset value
// ****************************************************************
`define CTRL_WIDTH8_BIT 0
`define CTRL_DEC_N_BIT  1
`define CTRL_FIFO_N_BIT 2
`define CTRL_POL_BIT    3
`define CTRL_ST_N_BIT   4
`define CTRL_RESET      5'h17

// ****************************************************************
// axi responses
// ****************************************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ****************************************************************
// timing and self-test sequence
// ****************************************************************
`define CHAR_DIV_DEF    8'h0A
`define SEQ_LEN         9'h1FF
`define SEQ_SEED        9'h1FF

`endif

/* File: rx_port_pkg.sv */
package rx_port_pkg;

  // control bits, width select in bit 0
  typedef struct packed {
    logic st_n;
    logic pol;
    logic fifo_n;
    logic dec_n;
    logic width8;
  } ctrl_t;

  // one character from the decoder
  typedef struct packed {
    logic [11:0] bits;
    logic        is_cmd;
    logic        viol;
  } rx_char_t;

  // whole state of the port
  typedef struct packed {
    ctrl_t       ctrl;
    logic [2:0]  clk_s;
    logic [1:0]  en_s;
    logic [1:0]  ce_s;
    logic [7:0]  div_cnt;
    logic        clk_out;
    logic        clk_oe;
    logic        ce_low_prev;
    rx_char_t    pend;
    logic        pend_valid;
    logic [9:0]  data_hold;
    logic [3:0]  cmd_hold;
    logic [11:0] bits;
    logic        ind;
    logic        flag;
    logic        oe;
    logic [8:0]  lfsr;
    logic [8:0]  seq_pos;
    logic [7:0]  loops;
    logic [7:0]  overruns;
    logic [15:0] mismatches;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_strb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage

/* File: rx_parallel_port.sv */
`timescale 1ns/1ps
`include "rx_port_defs.svh"
// Overview of operation
// - 8-bit decoded: bits 9:8 carry upper command bits of latest command.
// - 10-bit decoded: bits 9:8 carry bits 9:8 of latest data character.
// - decoder bypassed: bits 9:8 carry raw character bits nine and ten.
// - decoded: bits 11:10 carry low command bits of latest command.
// - 8-bit bypassed: bits 11:10 are driven low.
// - 10-bit bypassed: bits 11:10 carry raw bits eleven and twelve.
// - outputs update on the interface clock rising edge.
// - selected when enable active one edge after chip enable low.
// - selected drives pins after edge; deselect floats them after edge.
// - enable polarity follows the external queue polarity select.
// - character delivered in the cycle after an enabled edge.
// - 8-bit decoded: indicator high means new command, else new data.
// - 10-bit decoded: indicator high means new command, else new data.
// - decoder bypassed: indicator carries no function, held low.
// - violation flags bad sub-character; data and command stay unchanged.
// - each violation assertion lasts one interface clock period.
// - self-test mode reports sequence mismatches on the violation flag.
// - decoder bypassed outside self-test: violation flag held low.
// - read enable also floats the violation flag with the buses.
// - decoded data low byte on bits 7:0; commands leave it alone.
// - interface clock is host input with queue, else recovered output.
// - self-test compares each character with a 511-character sequence.
module rx_parallel_port
  import rx_port_pkg::*;
#(
  parameter logic [7:0] CHAR_DIV = `CHAR_DIV_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // characters from the decoder
  input  wire logic        char_valid_i,
  input  wire rx_char_t    char_i,
  // host pins
  input  wire logic        rx_iface_clock_i,
  output logic             rx_iface_clock_o,
  output logic             rx_iface_clock_oe_o,
  input  wire logic        rx_read_enable_i,
  input  wire logic        chip_enable_n_i,
  output logic [11:0]      rx_char_bits_o,
  output logic             cmd_or_data_indicator_o,
  output logic             code_violation_flag_o,
  output logic             rx_bus_oe_o,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  if (CHAR_DIV < 8'h02) begin : g_bad_div
    $error("CHAR_DIV must be at least 2");
  end

  state_t st_r;
  state_t st_nxt;
  logic   edge_c;
  logic   en_act_c;
  logic   sel_c;
  logic   deliver_c;
  logic   new_viol_c;
  logic   seq_miss_c;
  logic   fb_c;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.clk_s = {st_r.clk_s[1:0], rx_iface_clock_i};
    st_nxt.en_s  = {st_r.en_s[0], rx_read_enable_i};
    st_nxt.ce_s  = {st_r.ce_s[0], chip_enable_n_i};

    // recovered character clock when the queue is bypassed
    if (st_r.div_cnt >= CHAR_DIV - 8'h01) begin
      st_nxt.div_cnt = 8'h00;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end
    st_nxt.clk_out = (st_nxt.div_cnt < (CHAR_DIV >> 1));
    // interface clock rising edge, own or host supplied
    if (st_r.ctrl.fifo_n) begin
      edge_c = st_r.clk_s[1] && !st_r.clk_s[2];
    end else begin
      edge_c = st_nxt.clk_out && !st_r.clk_out;
    end

    en_act_c = st_r.ctrl.pol ? st_r.en_s[1] : !st_r.en_s[1];
    sel_c    = en_act_c && st_r.ce_low_prev;
    deliver_c = edge_c && sel_c && st_r.pend_valid;

    // self-test sequence check
    seq_miss_c = char_i.bits[8:0] != st_r.lfsr;
    fb_c       = st_r.lfsr[8] ^ st_r.lfsr[4];
    if (char_valid_i && !st_r.ctrl.st_n) begin
      st_nxt.lfsr = {st_r.lfsr[7:0], fb_c};
      if (st_r.seq_pos == `SEQ_LEN - 9'h001) begin
        st_nxt.seq_pos = 9'h000;
        st_nxt.loops   = st_r.loops + 8'h01;
      end else begin
        st_nxt.seq_pos = st_r.seq_pos + 9'h001;
      end
      if (seq_miss_c) begin
        st_nxt.mismatches = st_r.mismatches + 16'h0001;
      end
    end
    if (st_r.ctrl.st_n) begin
      st_nxt.lfsr    = `SEQ_SEED;
      st_nxt.seq_pos = 9'h000;
    end

    // pending character: a new arrival wins over the delivery clear
    if (deliver_c) begin
      st_nxt.pend_valid = 1'b0;
    end
    if (char_valid_i) begin
      st_nxt.pend       = char_i;
      st_nxt.pend_valid = 1'b1;
      if (!st_r.ctrl.st_n) begin
        st_nxt.pend.viol = seq_miss_c;
      end else if (!st_r.ctrl.dec_n) begin
        st_nxt.pend.viol = 1'b0;
      end
      if (st_r.pend_valid && !deliver_c) begin
        st_nxt.overruns = st_r.overruns + 8'h01;
      end
    end

    new_viol_c = st_r.pend.viol && (st_r.ctrl.dec_n || !st_r.ctrl.st_n);

    // interface edge: selection, delivery, flag timing
    if (edge_c) begin
      st_nxt.ce_low_prev = !st_r.ce_s[1];
      st_nxt.oe   = sel_c;
      st_nxt.flag = 1'b0;
      if (deliver_c) begin
        if (new_viol_c) begin
          st_nxt.flag = 1'b1;
        end else if (!st_r.ctrl.dec_n) begin
          st_nxt.ind = 1'b0;
          st_nxt.bits[9:0] = st_r.pend.bits[9:0];
          if (st_r.ctrl.width8) begin
            st_nxt.bits[11:10] = 2'h0;
          end else begin
            st_nxt.bits[11:10] = st_r.pend.bits[11:10];
          end
        end else if (st_r.pend.is_cmd) begin
          st_nxt.ind = 1'b1;
          if (st_r.ctrl.width8) begin
            st_nxt.cmd_hold = st_r.pend.bits[3:0];
          end else begin
            st_nxt.cmd_hold[1:0] = st_r.pend.bits[1:0];
          end
        end else begin
          st_nxt.ind = 1'b0;
          if (st_r.ctrl.width8) begin
            st_nxt.data_hold[7:0] = st_r.pend.bits[7:0];
          end else begin
            st_nxt.data_hold = st_r.pend.bits[9:0];
          end
        end
        if (!new_viol_c && st_r.ctrl.dec_n) begin
          st_nxt.bits[11:10] = st_nxt.cmd_hold[1:0];
          st_nxt.bits[7:0]   = st_nxt.data_hold[7:0];
          if (st_r.ctrl.width8) begin
            st_nxt.bits[9] = st_nxt.cmd_hold[2];
            st_nxt.bits[8] = st_nxt.cmd_hold[3];
          end else begin
            st_nxt.bits[9:8] = st_nxt.data_hold[9:8];
          end
        end
      end
    end
    if (!st_r.ctrl.dec_n && st_r.ctrl.st_n) begin
      st_nxt.flag = 1'b0;
    end

    // ****************************************************************
    // axi4-lite write
    // ****************************************************************
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = s_axi_wdata;
      st_nxt.w_strb0 = s_axi_wstrb[0];
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = `RESP_OKAY;
      if (st_r.aw_addr == `OFS_CTRL) begin
        if (st_r.w_strb0) begin
          st_nxt.ctrl = st_r.w_data[4:0];
        end
      end else if (st_r.aw_addr != `OFS_STATUS &&
                   st_r.aw_addr != `OFS_SELFTEST) begin
        st_nxt.bresp = `RESP_SLVERR;
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.clk_oe  = !st_nxt.ctrl.fifo_n;

    // ****************************************************************
    // axi4-lite read
    // ****************************************************************
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        `OFS_CTRL: begin
          st_nxt.rdata = {27'h0000000, st_r.ctrl};
        end
        `OFS_STATUS: begin
          st_nxt.rdata = {st_r.mismatches, st_r.overruns, 4'h0,
                          st_r.ind, st_r.flag, st_r.oe,
                          st_r.pend_valid};
        end
        `OFS_SELFTEST: begin
          st_nxt.rdata = {15'h0000, st_r.seq_pos, st_r.loops};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r         <= '0;
      st_r.ctrl    <= `CTRL_RESET;
      st_r.lfsr    <= `SEQ_SEED;
      st_r.clk_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rx_iface_clock_o        = st_r.clk_out;
  assign rx_iface_clock_oe_o     = st_r.clk_oe;
  assign rx_char_bits_o          = st_r.bits;
  assign cmd_or_data_indicator_o = st_r.ind;
  assign code_violation_flag_o   = st_r.flag;
  assign rx_bus_oe_o             = st_r.oe;
  assign s_axi_awready           = st_r.awready;
  assign s_axi_wready            = st_r.wready;
  assign s_axi_bvalid            = st_r.bvalid;
  assign s_axi_bresp             = st_r.bresp;
  assign s_axi_arready           = st_r.arready;
  assign s_axi_rvalid            = st_r.rvalid;
  assign s_axi_rdata             = st_r.rdata;
  assign s_axi_rresp             = st_r.rresp;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_flag_one_period;
    @(posedge clk_i) disable iff (rst_i)
    (st_r.flag && edge_c && !(deliver_c && new_viol_c)) |=> !st_r.flag;
  endproperty
  a_flag_one_period: assert property (p_flag_one_period)
    else $error("violation flag held past one period");

  property p_flag_low_bypass;
    @(posedge clk_i) disable iff (rst_i)
    $rose(st_r.flag) |-> ($past(st_r.ctrl.dec_n) || !$past(st_r.ctrl.st_n));
  endproperty
  a_flag_low_bypass: assert property (p_flag_low_bypass)
    else $error("violation flag raised with decoder bypassed");

  property p_data_delivered;
    @(posedge clk_i) disable iff (rst_i)
    (deliver_c && !new_viol_c && st_r.ctrl.dec_n && !st_r.pend.is_cmd)
      |=> (st_r.bits[7:0] == $past(st_r.pend.bits[7:0])) && !st_r.ind;
  endproperty
  a_data_delivered: assert property (p_data_delivered)
    else $error("data character not delivered after enabled edge");

  property p_cmd_keeps_data;
    @(posedge clk_i) disable iff (rst_i)
    (deliver_c && !new_viol_c && st_r.ctrl.dec_n && st_r.pend.is_cmd)
      |=> $stable(st_r.bits[7:0]) && st_r.ind;
  endproperty
  a_cmd_keeps_data: assert property (p_cmd_keeps_data)
    else $error("command character disturbed data bits");

  property p_oe_after_select;
    @(posedge clk_i) disable iff (rst_i)
    $rose(st_r.oe) |-> $past(edge_c && sel_c);
  endproperty
  a_oe_after_select: assert property (p_oe_after_select)
    else $error("bus enabled without selection");

  property p_bypass8_high_low;
    @(posedge clk_i) disable iff (rst_i)
    (deliver_c && !st_r.ctrl.dec_n && st_r.ctrl.width8 && st_r.ctrl.st_n)
      |=> st_r.bits[11:10] == 2'h0 && !st_r.ind;
  endproperty
  a_bypass8_high_low: assert property (p_bypass8_high_low)
    else $error("upper bits not low in 8-bit bypass");

  property p_viol_holds_bits;
    @(posedge clk_i) disable iff (rst_i)
    (deliver_c && new_viol_c) |=> $stable(st_r.bits) && st_r.flag;
  endproperty
  a_viol_holds_bits: assert property (p_viol_holds_bits)
    else $error("outputs changed on violation");

  property p_bits_on_edge;
    @(posedge clk_i) disable iff (rst_i)
    $changed(st_r.bits) |-> $past(deliver_c);
  endproperty
  a_bits_on_edge: assert property (p_bits_on_edge)
    else $error("outputs changed away from interface edge");

  property p_ten_bit_cmd;
    @(posedge clk_i) disable iff (rst_i)
    (deliver_c && !new_viol_c && st_r.ctrl.dec_n && st_r.pend.is_cmd &&
     !st_r.ctrl.width8)
      |=> st_r.bits[11:10] == $past(st_r.pend.bits[1:0]);
  endproperty
  a_ten_bit_cmd: assert property (p_ten_bit_cmd)
    else $error("command bits not on bits 11:10");

endmodule

/* File: host_reader.sv */
`timescale 1ns/1ps
// ****************************************************************
// host logic reading the receive parallel bus
// ****************************************************************
module host_reader (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic pol_i,
  input  wire logic sel_i,
  input  wire logic en_i,
  output logic      rx_iface_clock_o,
  output logic      rx_read_enable_o,
  output logic      chip_enable_n_o
);
  logic [2:0] phase_r;

  // clock stands low between frames, 80 ns period within them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 3'h0;
    end else if (run_i) begin
      phase_r <= phase_r + 3'h1;
    end else begin
      phase_r <= 3'h0;
    end
  end

  assign rx_iface_clock_o = phase_r[2];
  assign rx_read_enable_o = pol_i ? en_i : ~en_i;
  assign chip_enable_n_o  = ~sel_i;
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`include "rx_port_defs.svh"
module tb
  import rx_port_pkg::*;
;
  localparam logic [7:0] DIV   = 8'h04;
  localparam int         LIMIT = 20000;
  logic        clk_i, rst_i, char_valid_i, run, pol, sel, en;
  rx_char_t    char_i;
  logic        host_clk, rx_read_enable_i, chip_enable_n_i, rx_iface_clock_i;
  logic        rx_iface_clock_o, rx_iface_clock_oe_o;
  logic [11:0] rx_char_bits_o, raw_q;
  logic        cmd_or_data_indicator_o, code_violation_flag_o, rx_bus_oe_o;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, cmd_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ind_q;
  logic [9:0]  data_q;
  logic [4:0]  ctrl_q;
  int          fails, samples_checked, cycles, flag_cnt;

  // ****************************************************************
  // design, host and shared clock pin
  // ****************************************************************
  rx_parallel_port #(.CHAR_DIV(DIV)) u_rx_parallel_port (
    .clk_i, .rst_i, .char_valid_i, .char_i, .rx_iface_clock_i,
    .rx_iface_clock_o, .rx_iface_clock_oe_o, .rx_read_enable_i,
    .chip_enable_n_i, .rx_char_bits_o, .cmd_or_data_indicator_o,
    .code_violation_flag_o, .rx_bus_oe_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  host_reader u_host_reader (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .pol_i(pol), .sel_i(sel), .en_i(en), .rx_iface_clock_o(host_clk),
    .rx_read_enable_o(rx_read_enable_i),
    .chip_enable_n_o(chip_enable_n_i));
  assign rx_iface_clock_i = rx_iface_clock_oe_o ? rx_iface_clock_o : host_clk;

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (code_violation_flag_o === 1'b1) flag_cnt <= flag_cnt + 1;
    if (cycles == LIMIT) begin
      fails++;
      complete_run();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1 && !aw_d) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_d) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic set_ctrl(input logic [4:0] v);
    axi_wr(`OFS_CTRL, {27'h0, v});
    check(r, `RESP_OKAY);
    ctrl_q = v;
    pol <= v[3];
  endtask

  function automatic logic [11:0] exp_bits();
    case (ctrl_q[1:0])
      2'b11:   return {cmd_q[1], cmd_q[0], cmd_q[2], cmd_q[3], data_q[7:0]};
      2'b10:   return {cmd_q[1:0], data_q};
      2'b01:   return {2'b00, raw_q[9:0]};
      default: return raw_q;
    endcase
  endfunction

  // host clock burst of three rising edges, then settle
  task automatic burst();
    run <= 1'b1;
    repeat (24) @(posedge clk_i);
    run <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // one character, one host clock burst, then settle
  task automatic deliver(input logic [11:0] b, input logic c, input logic v,
                         input bit chk);
    int fc0;
    int fexp;
    fc0 = flag_cnt;
    fexp = (ctrl_q[1] && v) ? (ctrl_q[2] ? 8 : int'(DIV)) : 0;
    char_i <= '{bits: b, is_cmd: c, viol: v};
    char_valid_i <= 1'b1;
    @(posedge clk_i);
    char_valid_i <= 1'b0;
    burst();
    if (chk) begin
      raw_q = b;
      if (!ctrl_q[1]) ind_q = 1'b0;
      else if (!v && c && ctrl_q[0]) {cmd_q, ind_q} = {b[3:0], 1'b1};
      else if (!v && c) {cmd_q[1:0], ind_q} = {b[1:0], 1'b1};
      else if (!v && ctrl_q[0]) {data_q[7:0], ind_q} = {b[7:0], 1'b0};
      else if (!v) {data_q, ind_q} = {b[9:0], 1'b0};
      check(rx_char_bits_o, exp_bits());
      check(cmd_or_data_indicator_o, ind_q);
      check(flag_cnt - fc0, fexp);
      check(rx_bus_oe_o, 1'b1);
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h4375));
    {char_valid_i, run, pol, sel, en, cycles, flag_cnt} = '0;
    {sel, en, char_i, ind_q, fails, samples_checked} = '0;
    {data_q, cmd_q, raw_q} = '0;
    {sel, en} = 2'b11;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({code_violation_flag_o, cmd_or_data_indicator_o}, 2'b00);
    axi_rd(`OFS_CTRL);
    check(d, {27'h0, `CTRL_RESET});
    axi_rd(8'h0C);
    check(d, 32'h0);
    check(r, `RESP_SLVERR);
    for (int m = 0; m < 5; m++) begin
      set_ctrl(m < 4 ? {3'b101, 2'(m)} : 5'h12);
      check(rx_iface_clock_oe_o, m == 4);
      deliver(12'($urandom), 1'b0, 1'b0, 1);
      deliver(12'($urandom), 1'b1, 1'b0, 1);
      deliver(12'($urandom), 1'b0, 1'b1, 1);
      repeat (6) deliver(12'($urandom), 1'($urandom), ($urandom % 5) == 0, 1);
    end
    set_ctrl(5'h17);
    deliver(12'($urandom), 1'b0, 1'b0, 1);
    en <= 1'b0;
    deliver(12'($urandom), 1'b1, 1'b0, 0);
    check(rx_bus_oe_o, 1'b0);
    axi_rd(`OFS_STATUS);
    check(d[0], 1'b1);
    set_ctrl(5'h1F);
    en <= 1'b1;
    deliver(12'($urandom), 1'b1, 1'b0, 1);
    sel <= 1'b0;
    burst();
    check(rx_bus_oe_o, 1'b0);
    deliver(12'($urandom), 1'b0, 1'b0, 0);
    check(rx_char_bits_o, exp_bits());
    axi_rd(`OFS_STATUS);
    check(d[0], 1'b1);
    sel <= 1'b1;
    deliver(12'($urandom), 1'b0, 1'b0, 1);
    axi_rd(`OFS_STATUS);
    check(d[0], 1'b0);
    set_ctrl(5'h0F);
    axi_rd(`OFS_STATUS);
    raw_q = d[27:16];
    deliver(12'h000, 1'b0, 1'b0, 0);
    axi_rd(`OFS_STATUS);
    check(d[27:16] != raw_q, 1'b1);
    axi_rd(`OFS_SELFTEST);
    check(r, `RESP_OKAY);
    complete_run();
  end
endmodule
